// [core/ext_bus_pkg.sv]
// Operation
// RULE_01 - Read-modify-write port operands come from latch.
// RULE_02 - Bit operations rewrite whole latch byte.
// RULE_03 - Plain port reads return pin levels; portSel 1 reads 8'hff instead.
// RULE_04 - Separate fetch, data read, data write strobes.
// RULE_05 - Fetch 16-bit; data 16 or 8 bit.
// RULE_06 - High port drives address, latch untouched.
// RULE_07 - High port latch reappears after data cycle.
// RULE_08 - Byte pointer cycle keeps latch on pins.
// RULE_09 - Low port multiplexes address and data, push-pull.
// RULE_10 - Low address valid at strobe falling edge.
// RULE_11 - Write data surrounds the write strobe.
// RULE_12 - Read data sampled before strobe release.
// RULE_13 - External access loads ones into low latch.
// RULE_14 - Software avoids low latch writes during fetch.
// RULE_15 - External fetch when select active or beyond limit.
// RULE_16 - Boards without code memory hold select low.
// RULE_17 - High port emits counter upper byte on fetch.
// RULE_18 - Data strobes reach pins only if latch bit set.
package ext_bus_pkg;
	localparam logic [7:0]  PORT_RESET     = 8'hff;
	localparam logic [15:0] ROM_LIMIT_SMALL = 16'h0fff;
	localparam logic [15:0] ROM_LIMIT_LARGE = 16'h1fff;
	localparam int          WR_BIT         = 6;
	localparam int          RD_BIT         = 7;
	localparam logic [2:0]  PH_ADDR        = 3'h0;
	localparam logic [2:0]  PH_LAST        = 3'h5;

	typedef enum logic [1:0] {
		ACC_FETCH,
		ACC_READ,
		ACC_WRITE
	} acc_kind_t;

	typedef enum {
		IDLE,
		BUSY
	} bus_state_t;
endpackage

// [core/ext_memory_bus.sv]
module ext_memory_bus
	import ext_bus_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic        largePart,
	input  wire logic        extAccessSelectN,
	input  wire logic [15:0] pc,
	input  wire logic        accStart,
	input  wire logic [1:0]  accKind,
	input  wire logic        accWide,
	input  wire logic [15:0] accAddr,
	input  wire logic [7:0]  accWrData,
	output logic             accBusy,
	output logic             accDone,
	output logic [7:0]       accRdData,
	output logic             fetchExternal,
	input  wire logic [1:0]  portSel,
	input  wire logic        portRmw,
	input  wire logic        portWrite,
	input  wire logic        portBitOp,
	input  wire logic [2:0]  portBitIdx,
	input  wire logic        portBitVal,
	input  wire logic [7:0]  portWrData,
	output logic [7:0]       portRdData,
	input  wire logic [7:0]  lowPortIn,
	output logic [7:0]       lowPortOut,
	output logic [7:0]       lowPortOeN,
	input  wire logic [7:0]  highPortIn,
	output logic [7:0]       highPortOut,
	output logic [7:0]       highPortStrongN,
	input  wire logic [7:0]  ctrlPortIn,
	output logic [7:0]       ctrlPortOut,
	output logic             addressLatchStrobe,
	output logic             programFetchStrobeN
);
	logic [7:0] lowLatch_q, highLatch_q, ctrlLatch_q, auxLatch_q;
	logic [7:0] lowSync1_q, lowSync_q, highSync1_q, highSync_q, ctrlSync1_q, ctrlSync_q;
	bus_state_t state_q;
	logic [2:0]  phase_q;
	acc_kind_t   kind_q;
	logic        wide_q;
	logic [15:0] addr_q;
	logic [7:0]  wdata_q, rdata_q, lowOut_q, highOut_q;
	logic        lowDrive_q, highDrive_q, ale_q, fetchN_q, rdN_q, wrN_q, done_q;

	function automatic logic [7:0] setBit(input logic [7:0] b, input logic [2:0] i,
		input logic v);
		logic [7:0] r;
		r = b;
		r[i] = v;
		return r;
	endfunction

	wire logic [7:0] selLatch = (portSel == 2'h0) ? lowLatch_q :
		(portSel == 2'h1) ? auxLatch_q : (portSel == 2'h2) ? highLatch_q : ctrlLatch_q;
	wire logic [7:0] selPin = (portSel == 2'h0) ? lowSync_q :
		(portSel == 2'h1) ? 8'hff : (portSel == 2'h2) ? highSync_q : ctrlSync_q;
	wire logic [15:0] romLimit = largePart ? ROM_LIMIT_LARGE : ROM_LIMIT_SMALL;
	wire logic [7:0] newByte = portBitOp ? setBit(selLatch, portBitIdx, portBitVal) // RULE_02
		: portWrData;
	wire logic startOk = accStart && (state_q == IDLE);

	assign portRdData = portRmw ? selLatch : selPin; // RULE_01 RULE_03
	assign fetchExternal = !extAccessSelectN || (pc > romLimit); // RULE_15
	assign accBusy = (state_q == BUSY);
	assign accDone = done_q;
	assign accRdData = rdata_q;
	assign lowPortOut = lowDrive_q ? lowOut_q : 8'h00;
	assign lowPortOeN = lowDrive_q ? 8'h00 : lowLatch_q; // RULE_09
	assign highPortOut = highDrive_q ? highOut_q : highLatch_q; // RULE_06 RULE_07 RULE_08
	assign highPortStrongN = highDrive_q ? ~highOut_q : 8'hff; // RULE_17
	assign ctrlPortOut = {ctrlLatch_q[RD_BIT] & rdN_q, ctrlLatch_q[WR_BIT] & wrN_q, // RULE_18
		ctrlLatch_q[5:0]};
	assign addressLatchStrobe = ale_q;
	assign programFetchStrobeN = fetchN_q; // RULE_04

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			lowSync1_q <= 8'h00;
			lowSync_q <= 8'h00;
			highSync1_q <= 8'h00;
			highSync_q <= 8'h00;
			ctrlSync1_q <= 8'h00;
			ctrlSync_q <= 8'h00;
		end else begin
			lowSync1_q <= lowPortIn;
			lowSync_q <= lowSync1_q;
			highSync1_q <= highPortIn;
			highSync_q <= highSync1_q;
			ctrlSync1_q <= ctrlPortIn;
			ctrlSync_q <= ctrlSync1_q;
		end
	end

	// Port latches; the high latch is never touched by bus cycles.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			lowLatch_q <= PORT_RESET;
			auxLatch_q <= PORT_RESET;
			highLatch_q <= PORT_RESET;
			ctrlLatch_q <= PORT_RESET;
		end else begin
			if (portWrite && portSel == 2'h1)
				auxLatch_q <= newByte;
			if (portWrite && portSel == 2'h2)
				highLatch_q <= newByte;
			if (portWrite && portSel == 2'h3)
				ctrlLatch_q <= newByte;
			if (startOk)
				lowLatch_q <= PORT_RESET; // RULE_13
			else if (portWrite && portSel == 2'h0)
				lowLatch_q <= newByte;
		end
	end

	// Bus cycle: phase 0 address with strobe high, 1 strobe falls, 1..4 fetch/read strobe, 3..4 write strobe, 5 ends.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_q <= IDLE;
			phase_q <= PH_ADDR;
			kind_q <= ACC_FETCH;
			wide_q <= 1'b0;
			addr_q <= 16'h0000;
			wdata_q <= 8'h00;
		end else begin
			case (state_q)
				IDLE: begin
					if (accStart) begin
						state_q <= BUSY;
						phase_q <= PH_ADDR;
						kind_q <= acc_kind_t'(accKind);
						wide_q <= accWide || (accKind == 2'h0); // RULE_05
						addr_q <= accAddr;
						wdata_q <= accWrData;
					end
				end
				BUSY: begin
					if (phase_q == PH_LAST)
						state_q <= IDLE;
					phase_q <= phase_q + 3'h1;
				end
				default: state_q <= IDLE;
			endcase
		end
	end

	wire logic busy = (state_q == BUSY);
	wire logic strobePh = busy && phase_q >= 3'h2 && phase_q <= 3'h4;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			lowOut_q <= 8'h00;
			lowDrive_q <= 1'b0;
			highOut_q <= 8'h00;
			highDrive_q <= 1'b0;
			ale_q <= 1'b0;
			fetchN_q <= 1'b1;
			rdN_q <= 1'b1;
			wrN_q <= 1'b1;
			rdata_q <= 8'h00;
			done_q <= 1'b0;
		end else begin
			ale_q <= startOk; // RULE_10
			lowDrive_q <= startOk || (busy && phase_q == PH_ADDR) ||
				(busy && kind_q == ACC_WRITE && phase_q < PH_LAST); // RULE_11
			lowOut_q <= startOk ? accAddr[7:0] : (busy && phase_q == PH_ADDR) ? addr_q[7:0] :
				wdata_q; // RULE_09
			highDrive_q <= startOk ? (accWide || accKind == 2'h0) :
				(busy && phase_q != PH_LAST && wide_q); // RULE_06
			highOut_q <= startOk ? accAddr[15:8] : addr_q[15:8];
			fetchN_q <= !((busy && phase_q <= 3'h3) && kind_q == ACC_FETCH);
			rdN_q <= !((busy && phase_q <= 3'h3) && kind_q == ACC_READ);
			wrN_q <= !(strobePh && phase_q != 3'h4 && kind_q == ACC_WRITE); // RULE_11
			if (busy && phase_q == 3'h4 && kind_q != ACC_WRITE)
				rdata_q <= lowSync_q; // RULE_12
			done_q <= busy && phase_q == 3'h4;
		end
	end

	property p_ones_on_access;
		@(posedge mclk) disable iff (reset) startOk |=> lowLatch_q == PORT_RESET;
	endproperty
	a_ones_on_access: assert property (p_ones_on_access) else $error("low latch not ones"); // RULE_13

	property p_high_latch_kept;
		@(posedge mclk) disable iff (reset) busy && !portWrite |=> $stable(highLatch_q);
	endproperty
	a_high_latch_kept: assert property (p_high_latch_kept) else $error("high latch moved"); // RULE_06

	property p_ale_addr;
		@(posedge mclk) disable iff (reset) ale_q |-> lowDrive_q ##1 !ale_q;
	endproperty
	a_ale_addr: assert property (p_ale_addr) else $error("address not driven"); // RULE_10

	property p_write_data;
		@(posedge mclk) disable iff (reset) !wrN_q |-> lowDrive_q && lowOut_q == wdata_q;
	endproperty
	a_write_data: assert property (p_write_data) else $error("write data missing"); // RULE_11

	property p_narrow_page;
		@(posedge mclk) disable iff (reset) busy && !wide_q |-> highPortOut == highLatch_q;
	endproperty
	a_narrow_page: assert property (p_narrow_page) else $error("page byte lost"); // RULE_08

	property p_release;
		@(posedge mclk) disable iff (reset) done_q ##1 !busy |-> !highDrive_q;
	endproperty
	a_release: assert property (p_release) else $error("latch not restored"); // RULE_07

	property p_strobe_gate;
		@(posedge mclk) disable iff (reset) !ctrlLatch_q[RD_BIT] |-> !ctrlPortOut[RD_BIT];
	endproperty
	a_strobe_gate: assert property (p_strobe_gate) else $error("read strobe leaked"); // RULE_18

	property p_rmw_latch;
		@(posedge mclk) disable iff (reset) portRmw |-> portRdData == selLatch;
	endproperty
	a_rmw_latch: assert property (p_rmw_latch) else $error("rmw read pin"); // RULE_01

	property p_strobes_exclusive;
		@(posedge mclk) disable iff (reset) !(!fetchN_q && (!rdN_q || !wrN_q));
	endproperty
	a_strobes_exclusive: assert property (p_strobes_exclusive) else $error("strobe clash"); // RULE_04

	sequence s_fetch_start;
		startOk && accKind == 2'h0;
	endsequence

	sequence s_read_start;
		startOk && accKind == 2'h1;
	endsequence

	sequence s_write_start;
		startOk && accKind == 2'h2;
	endsequence

	property p_fetch_strobe;
		@(posedge mclk) disable iff (reset) s_fetch_start |=> ##1 !fetchN_q [*4] ##1 fetchN_q;
	endproperty
	a_fetch_strobe: assert property (p_fetch_strobe) else $error("fetch strobe shape"); // RULE_04

	property p_read_strobe;
		@(posedge mclk) disable iff (reset) s_read_start |=> ##1 !rdN_q [*4] ##1 rdN_q;
	endproperty
	a_read_strobe: assert property (p_read_strobe) else $error("read strobe shape"); // RULE_04

	property p_write_strobe;
		@(posedge mclk) disable iff (reset) s_write_start |=> ##3 !wrN_q [*2] ##1 wrN_q;
	endproperty
	a_write_strobe: assert property (p_write_strobe) else $error("write strobe shape"); // RULE_11

	property p_fetch_no_data;
		@(posedge mclk) disable iff (reset) s_fetch_start |=> (rdN_q && wrN_q) [*6];
	endproperty
	a_fetch_no_data: assert property (p_fetch_no_data) else $error("data strobe in fetch"); // RULE_04

	property p_ale_pulse;
		@(posedge mclk) disable iff (reset) startOk |=> ale_q ##1 !ale_q;
	endproperty
	a_ale_pulse: assert property (p_ale_pulse) else $error("address strobe shape"); // RULE_10

	property p_addr_at_fall;
		@(posedge mclk) disable iff (reset) $fell(ale_q) |-> lowDrive_q && lowOut_q == addr_q[7:0];
	endproperty
	a_addr_at_fall: assert property (p_addr_at_fall) else $error("low address lost"); // RULE_10

	property p_wide_high;
		@(posedge mclk) disable iff (reset) busy && wide_q |->
			highPortOut == addr_q[15:8] && highPortStrongN == ~addr_q[15:8];
	endproperty
	a_wide_high: assert property (p_wide_high) else $error("high address missing"); // RULE_06

	property p_fetch_high;
		@(posedge mclk) disable iff (reset) busy && kind_q == ACC_FETCH |-> highDrive_q;
	endproperty
	a_fetch_high: assert property (p_fetch_high) else $error("fetch high byte off"); // RULE_17

	property p_bit_op;
		@(posedge mclk) disable iff (reset) portWrite && portBitOp && portSel == 2'h2 |=>
			((highLatch_q ^ $past(highLatch_q)) & ~(8'h01 << $past(portBitIdx))) == 8'h00;
	endproperty
	a_bit_op: assert property (p_bit_op) else $error("other bits changed"); // RULE_02

	property p_pin_read;
		@(posedge mclk) disable iff (reset) !portRmw |-> portRdData == selPin;
	endproperty
	a_pin_read: assert property (p_pin_read) else $error("plain read saw latch"); // RULE_03

	property p_push_pull;
		@(posedge mclk) disable iff (reset) lowDrive_q |-> lowPortOeN == 8'h00;
	endproperty
	a_push_pull: assert property (p_push_pull) else $error("low port not driven"); // RULE_09

	property p_write_gate;
		@(posedge mclk) disable iff (reset) !ctrlLatch_q[WR_BIT] |-> !ctrlPortOut[WR_BIT];
	endproperty
	a_write_gate: assert property (p_write_gate) else $error("write strobe leaked"); // RULE_18

	property p_done_end;
		@(posedge mclk) disable iff (reset) done_q |=> !done_q && !busy;
	endproperty
	a_done_end: assert property (p_done_end) else $error("cycle did not end"); // RULE_07

	property p_read_sample;
		@(posedge mclk) disable iff (reset) busy && phase_q == 3'h4 && kind_q != ACC_WRITE |=>
			accRdData == $past(lowSync_q);
	endproperty
	a_read_sample: assert property (p_read_sample) else $error("read byte not taken"); // RULE_12
endmodule

// [tb/ext_mem_model.sv]
module ext_mem_model (
	input  wire logic        ale,
	input  wire logic        fetchN,
	input  wire logic        rdN,
	input  wire logic        wrN,
	input  wire logic [7:0]  busIn,
	input  wire logic [7:0]  highIn,
	output logic             drive,
	output logic [7:0]       rdData,
	output logic [15:0]      wrAddr,
	output logic [7:0]       wrData
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] addr;
	always @(negedge ale) addr = {highIn, busIn};
	assign drive = !fetchN || !rdN;
	assign rdData = addr[15:8] ^ addr[7:0] ^ 8'ha5;
	always @(posedge wrN) begin
		wrAddr = addr;
		wrData = busIn;
	end
endmodule

// [tb/testbench.sv]
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
$display("CHECK FAILED %s exp %h got %h", n, e, g); end end
	logic mclk = 0, reset = 1, largePart = 0, extAccessSelectN = 1, accStart = 0, accWide = 0;
	logic portRmw = 0, portWrite = 0, portBitOp = 0, portBitVal = 0;
	logic [1:0]  accKind = 2'h0, portSel = 2'h0;
	logic [2:0]  portBitIdx = 3'h0;
	logic [7:0]  accWrData = 8'h00, portWrData = 8'h00, highPortIn = 8'hff, ctrlPortIn = 8'hff;
	logic [15:0] pc = 16'h0000, accAddr = 16'h0000, wrAddr;
	logic        accBusy, accDone, fetchExternal, addressLatchStrobe, programFetchStrobeN, memDrive;
	logic [7:0]  accRdData, portRdData, lowPortIn, lowPortOut, lowPortOeN, highPortOut;
	logic [7:0]  highPortStrongN, ctrlPortOut, memData, wrData;
	int          fails = 0, comparisons = 0;
	assign lowPortIn = (~lowPortOeN & lowPortOut) | (lowPortOeN & (memDrive ? memData : ~lowPortOut));
	ext_memory_bus dut (.mclk, .reset, .largePart, .extAccessSelectN, .pc, .accStart, .accKind,
		.accWide, .accAddr, .accWrData, .accBusy, .accDone, .accRdData, .fetchExternal, .portSel,
		.portRmw, .portWrite, .portBitOp, .portBitIdx, .portBitVal, .portWrData, .portRdData,
		.lowPortIn, .lowPortOut, .lowPortOeN, .highPortIn, .highPortOut, .highPortStrongN,
		.ctrlPortIn, .ctrlPortOut, .addressLatchStrobe, .programFetchStrobeN);
	ext_mem_model mem (.ale(addressLatchStrobe), .fetchN(programFetchStrobeN),
		.rdN(ctrlPortOut[7]), .wrN(ctrlPortOut[6]), .busIn(lowPortIn), .highIn(highPortOut),
		.drive(memDrive), .rdData(memData), .wrAddr(wrAddr), .wrData(wrData));
	initial forever #50 mclk = ~mclk;
	task print_verdict;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task acc(input logic [1:0] k, input logic w, input logic [15:0] a, input logic [7:0] d);
		int n;
		@(posedge mclk);
		accStart <= 1'b1;
		accKind <= k;
		accWide <= w;
		accAddr <= a;
		accWrData <= d;
		@(posedge mclk);
		accStart <= 1'b0;
		n = 0;
		while (accDone !== 1'b1 && n < 10) begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (n >= 10) begin
			fails++;
			print_verdict();
		end
	endtask
	task po(input logic [1:0] s, input logic [7:0] d, input logic b);
		@(posedge mclk);
		portSel <= s;
		portWrite <= 1'b1;
		portWrData <= d;
		portBitOp <= b;
		portBitIdx <= d[2:0];
		portBitVal <= d[3];
		@(posedge mclk);
		portWrite <= 1'b0;
		portBitOp <= 1'b0;
	endtask
	task pr(input logic [1:0] s, input logic r);
		@(posedge mclk);
		portSel <= s;
		portRmw <= r;
		repeat (3) @(posedge mclk);
		#1;
	endtask
	initial begin
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		for (int i = 0; i < 9; i++) begin
			@(posedge mclk);
			largePart <= i[0];
			extAccessSelectN <= i < 8;
			pc <= 16'h0fff + 16'(i[2:1]) * 16'h0800;
			#1;
			`CHK("fetchExternal", i == 8 || pc > (largePart ? 16'h1fff : 16'h0fff), fetchExternal)
		end
		acc(2'h0, 1'b0, 16'h8124, 8'h00);
		`CHK("fetch data", 8'h81 ^ 8'h24 ^ 8'ha5, accRdData)
		po(2'h0, 8'h00, 1'b0);
		po(2'h2, 8'h00, 1'b0);
		acc(2'h1, 1'b1, 16'hc35a, 8'h00);
		`CHK("read data", 8'hc3 ^ 8'h5a ^ 8'ha5, accRdData)
		pr(2'h0, 1'b1);
		`CHK("low latch", 8'hff, portRdData)
		pr(2'h2, 1'b1);
		`CHK("high latch", 8'h00, portRdData)
		po(2'h2, 8'h3c, 1'b0);
		acc(2'h2, 1'b0, 16'h1277, 8'h96);
		`CHK("page addr", 16'h3c77, wrAddr)
		`CHK("write data", 8'h96, wrData)
		acc(2'h2, 1'b1, 16'hab01, 8'h69);
		`CHK("wide addr", 16'hab01, wrAddr)
		@(posedge mclk);
		#1;
		`CHK("high pins", 8'h3c, highPortOut)
		@(posedge mclk);
		highPortIn <= 8'h00;
		po(2'h2, 8'h0f, 1'b0);
		pr(2'h2, 1'b1);
		`CHK("rmw read", 8'h0f, portRdData)
		pr(2'h2, 1'b0);
		`CHK("pin read", 8'h00, portRdData)
		po(2'h2, 8'h0f, 1'b1);
		pr(2'h2, 1'b1);
		`CHK("bit set", 8'h8f, portRdData)
		print_verdict();
	end
endmodule
